/* File: asp_pkg.sv */
package asp_pkg;
   // Port offsets within the sixteen-port block.
   localparam logic [3:0] DATA_OFFSET = 4'h6;
   localparam logic [3:0] CTRL_OFFSET = 4'h7;
   // Mode word fields.
   localparam int MODE_STOP_LSB = 6;
   localparam int MODE_PAR_SENSE = 5;
   localparam int MODE_PAR_ON = 4;
   localparam int MODE_LEN_LSB = 2;
   localparam int MODE_FACTOR_LSB = 0;
   // Command word fields.
   localparam int CMD_SOFT_RESET = 6;
   localparam int CMD_DSR = 5;
   localparam int CMD_FAULT_CLEAR = 4;
   localparam int CMD_BREAK = 3;
   localparam int CMD_RX_EN = 2;
   localparam int CMD_CTS = 1;
   localparam int CMD_TX_EN = 0;
   // Status byte layout.
   localparam int ST_TX_FREE = 0;
   localparam int ST_RX_AVAIL = 1;
   localparam int ST_TX_EMPTY = 2;
   localparam int ST_PARITY = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_FRAMING = 5;
   localparam int ST_BREAK = 6;
   // Values after reset.
   localparam logic [7:0] MODE_RESET = 8'h4E;
   localparam logic [7:0] CMD_RESET = 8'h00;
   // Clock factor codes.
   localparam logic [1:0] FACTOR_1X = 2'h1;
   localparam logic [1:0] FACTOR_16X = 2'h2;
   // Stop length codes.
   localparam logic [1:0] STOP_ONE = 2'h1;
   localparam logic [1:0] STOP_ONE_HALF = 2'h2;

   typedef struct packed {
      logic [1:0] stop_length_field;
      logic parity_sense;
      logic parity_on;
      logic [1:0] char_length_field;
      logic [1:0] clock_factor_field;
   } asp_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic parity_err;
      logic framing_err;
   } asp_rx_char_t;
endpackage

/* File: asp_port.sv */
// Notes on behaviour
// - Decode data port at offset 6 and control/status port at offset 7.
// - First control write after reset is the mode; later ones are commands.
// - Mode bits 7:6 give one, one and a half or two stop bits.
// - Receiver checks only one stop bit.
// - Mode bit 4 enables parity, bit 5 picks even over odd.
// - Mode bits 3:2 give five to eight data bits.
// - Mode bits 1:0 give clock factor 1x (the transmitter takes two bit clocks per bit), 16x or 64x.
// - Command bit 6 returns the port to waiting for a mode word.
// - Command bit 5 drives DSR, bit 1 drives CTS.
// - Command bit 4 clears parity, overrun and framing flags.
// - Command bit 3 holds the serial output at space.
// - Command bit 2 clear turns receiver and its ready flag off.
// - Transmit enable clear kills ready request but still buffers one character.
// - Status shows break detect, framing, overrun and parity errors.
// - Status shows transmitter empty, receive ready and transmit ready.
// - DTR gates transmission like transmit enable after the current character.
`timescale 1ns/1ns
`default_nettype none
module asp_port (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Host I/O access, one-cycle strobes.
   input wire logic i_sel,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Bit clock from the baud timer, a pin.
   input wire logic i_bit_clk,
   // Serial line.
   input wire logic i_rx_line,
   input wire logic i_dtr,
   output logic o_tx_line,
   output logic o_dsr,
   output logic o_cts,
   // Ready requests.
   output logic o_rx_request,
   output logic o_tx_request
);
   asp_pkg::asp_mode_t mode;
   logic [7:0] cmd;
   logic mode_pending;
   logic [1:0] rx_sync;
   logic [1:0] dtr_sync;
   logic [2:0] bclk_sync;
   logic bit_tick;
   logic data_wr;
   logic data_rd;
   logic ctrl_wr;
   logic ctrl_rd;
   logic [7:0] hold_data;
   logic hold_full;
   logic tx_start;
   logic tx_busy;
   logic tx_line;
   logic tx_go;
   asp_pkg::asp_rx_char_t rx_char;
   logic rx_done;
   logic rx_break;
   logic [7:0] rx_data;
   logic rx_avail;
   logic parity_mismatch_flag;
   logic overrun_flag;
   logic framing_flag;
   logic fault_clear;
   logic [7:0] status;
   logic soft_reset;

   assign data_wr = i_sel && i_wr && i_addr == asp_pkg::DATA_OFFSET;
   assign data_rd = i_sel && i_rd && i_addr == asp_pkg::DATA_OFFSET;
   assign ctrl_wr = i_sel && i_wr && i_addr == asp_pkg::CTRL_OFFSET;
   assign ctrl_rd = i_sel && i_rd && i_addr == asp_pkg::CTRL_OFFSET;
   assign soft_reset = ctrl_wr && !mode_pending && i_wdata[asp_pkg::CMD_SOFT_RESET];
   assign fault_clear = ctrl_wr && !mode_pending && i_wdata[asp_pkg::CMD_FAULT_CLEAR];

   // Pins cross in through two flip-flops; the bit clock edge is taken from the second stage onward.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_sync <= 2'h3;
         dtr_sync <= 2'h0;
         bclk_sync <= 3'h0;
      end else begin
         rx_sync <= {rx_sync[0], i_rx_line};
         dtr_sync <= {dtr_sync[0], i_dtr};
         bclk_sync <= {bclk_sync[1:0], i_bit_clk};
      end
   end
   assign bit_tick = bclk_sync[1] && !bclk_sync[2];

   // Mode and command words.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode <= asp_pkg::asp_mode_t'(asp_pkg::MODE_RESET);
         cmd <= asp_pkg::CMD_RESET;
         mode_pending <= 1'b1;
      end else if (ctrl_wr) begin
         if (mode_pending) begin
            mode <= asp_pkg::asp_mode_t'(i_wdata);
            mode_pending <= 1'b0;
         end else if (i_wdata[asp_pkg::CMD_SOFT_RESET]) begin
            cmd <= asp_pkg::CMD_RESET;
            mode_pending <= 1'b1;
         end else begin
            cmd <= i_wdata;
         end
      end
   end

   // Modem control outputs follow the command bits.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_dsr <= 1'b0;
         o_cts <= 1'b0;
      end else begin
         o_dsr <= cmd[asp_pkg::CMD_DSR];
         o_cts <= cmd[asp_pkg::CMD_CTS];
      end
   end

   // Transmit holding buffer; it fills even while the transmitter is gated off.
   assign tx_go = cmd[asp_pkg::CMD_TX_EN] && dtr_sync[1] && !mode_pending;
   assign tx_start = hold_full && !tx_busy && tx_go;
   always_ff @(posedge i_clk) begin
      if (i_rst || soft_reset) begin
         hold_full <= 1'b0;
         hold_data <= 8'h00;
      end else if (data_wr && !hold_full) begin
         hold_full <= 1'b1;
         hold_data <= i_wdata;
      end else if (tx_start) begin
         hold_full <= 1'b0;
      end
   end

   asp_tx u_tx (
      .i_clk(i_clk),
      .i_rst(i_rst || soft_reset),
      .i_mode(mode),
      .i_bit_tick(bit_tick),
      .i_break(cmd[asp_pkg::CMD_BREAK]),
      .i_start(tx_start),
      .i_data(hold_data),
      .o_line(tx_line),
      .o_busy(tx_busy)
   );

   asp_rx u_rx (
      .i_clk(i_clk),
      .i_rst(i_rst || soft_reset),
      .i_mode(mode),
      .i_bit_tick(bit_tick),
      .i_enable(cmd[asp_pkg::CMD_RX_EN]),
      .i_line(rx_sync[1]),
      .o_char(rx_char),
      .o_done(rx_done),
      .o_break(rx_break)
   );

   // Receive buffer and error flags; a new error wins over a clear in the same cycle.
   always_ff @(posedge i_clk) begin
      if (i_rst || soft_reset) begin
         rx_data <= 8'h00;
         rx_avail <= 1'b0;
         parity_mismatch_flag <= 1'b0;
         overrun_flag <= 1'b0;
         framing_flag <= 1'b0;
      end else begin
         if (fault_clear) begin
            parity_mismatch_flag <= 1'b0;
            overrun_flag <= 1'b0;
            framing_flag <= 1'b0;
         end
         if (data_rd) begin
            rx_avail <= 1'b0;
         end
         if (rx_done) begin
            rx_data <= rx_char.data;
            rx_avail <= 1'b1;
            if (rx_avail && !data_rd) begin
               overrun_flag <= 1'b1;
            end
            if (rx_char.parity_err) begin
               parity_mismatch_flag <= 1'b1;
            end
            if (rx_char.framing_err) begin
               framing_flag <= 1'b1;
            end
         end
      end
   end

   always_comb begin
      status = 8'h00;
      status[asp_pkg::ST_TX_FREE] = !hold_full;
      status[asp_pkg::ST_RX_AVAIL] = rx_avail && cmd[asp_pkg::CMD_RX_EN];
      status[asp_pkg::ST_TX_EMPTY] = !hold_full && !tx_busy;
      status[asp_pkg::ST_PARITY] = parity_mismatch_flag;
      status[asp_pkg::ST_OVERRUN] = overrun_flag;
      status[asp_pkg::ST_FRAMING] = framing_flag;
      status[asp_pkg::ST_BREAK] = rx_break;
   end

   // Registered outputs; read data is valid the cycle after the read strobe.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_tx_line <= 1'b1;
         o_rx_request <= 1'b0;
         o_tx_request <= 1'b0;
      end else begin
         if (data_rd) begin
            o_rdata <= rx_data;
         end else if (ctrl_rd) begin
            o_rdata <= status;
         end
         o_tx_line <= tx_line;
         o_rx_request <= rx_avail && cmd[asp_pkg::CMD_RX_EN];
         o_tx_request <= !hold_full && tx_go;
      end
   end
endmodule // asp_port
`default_nettype wire

/* File: asp_port_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_port_sva (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Host access.
   input wire logic i_sel,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   // Line side.
   input wire logic i_dtr,
   input wire logic o_tx_line,
   input wire logic o_dsr,
   input wire logic o_cts,
   input wire logic o_rx_request,
   input wire logic o_tx_request
);
   logic mode_wait;
   logic ctl_wr;
   logic cmd_wr;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   assign ctl_wr = i_sel && i_wr && i_addr == asp_pkg::CTRL_OFFSET;
   assign cmd_wr = ctl_wr && !mode_wait && !i_wdata[6];
   // A format write clears the wait; a control word with soft reset re-arms it.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode_wait <= 1'b1;
      end else if (ctl_wr) begin
         mode_wait <= !mode_wait && i_wdata[6];
      end
   end
   property p_dsr; cmd_wr |=> ##1 o_dsr == $past(i_wdata[5], 2); endproperty
   a_dsr: assert property (p_dsr) else $error("dsr does not follow control word");
   property p_cts; cmd_wr |=> ##1 o_cts == $past(i_wdata[1], 2); endproperty
   a_cts: assert property (p_cts) else $error("cts does not follow control word");
   property p_idle; $fell(i_rst) |-> o_tx_line && !o_dsr && !o_cts && !o_rx_request && !o_tx_request; endproperty
   a_idle: assert property (p_idle) else $error("outputs not idle after reset");
   property p_rx_off; cmd_wr && !i_wdata[2] |=> ##2 (!o_rx_request) [*4]; endproperty
   a_rx_off: assert property (p_rx_off) else $error("receive request while receiver off");
   property p_tx_off; cmd_wr && !i_wdata[0] |=> ##2 (!o_tx_request) [*4]; endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmit request while transmitter off");
   property p_dtr; (!i_dtr) [*6] |-> !o_tx_request; endproperty
   a_dtr: assert property (p_dtr) else $error("transmit request while dtr inactive");
   property p_brk; cmd_wr && i_wdata[3] |=> ##3 (!o_tx_line) [*8]; endproperty
   a_brk: assert property (p_brk) else $error("line not held at space during break");
   property p_full; i_sel && i_wr && i_addr == asp_pkg::DATA_OFFSET |=> ##1 !o_tx_request; endproperty
   a_full: assert property (p_full) else $error("transmit request right after data write");
   property p_bit7; i_sel && i_rd && i_addr == asp_pkg::CTRL_OFFSET |=> !o_rdata[7]; endproperty
   a_bit7: assert property (p_bit7) else $error("unused status bit set");
endmodule // asp_port_sva
bind asp_port asp_port_sva chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_sel(i_sel), .i_addr(i_addr), .i_wr(i_wr),
   .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_dtr(i_dtr), .o_tx_line(o_tx_line), .o_dsr(o_dsr),
   .o_cts(o_cts), .o_rx_request(o_rx_request), .o_tx_request(o_tx_request));
`default_nettype wire

/* File: asp_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_port_tb_top;
   localparam logic [3:0] DP = asp_pkg::DATA_OFFSET;
   localparam logic [3:0] CP = asp_pkg::CTRL_OFFSET;
   logic clk, rst, sel, wr, rd, bit_clk, dtr, rx_line, tx_line, dsr, cts, rxq, txq, got, rd_seen, ev;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [9:0] word;
   logic [9:0] exp_q[$];
   logic [9:0] tx_q[$];
   int n_errors, total_checks, nb, seed;

   asp_port dut_u (.i_clk(clk), .i_rst(rst), .i_sel(sel), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
      .o_rdata(rdata), .i_bit_clk(bit_clk), .i_rx_line(rx_line), .i_dtr(dtr), .o_tx_line(tx_line),
      .o_dsr(dsr), .o_cts(cts), .o_rx_request(rxq), .o_tx_request(txq));
   asp_term term_u (.i_line(tx_line), .i_nbits(4'(nb + 2)), .o_line(rx_line), .o_got(got), .o_word(word));

   always #5 clk = ~clk;
   // Stands in for the baud timer at sixteen times the bit rate.
   always #20 bit_clk = ~bit_clk;

   task automatic chk(input logic [9:0] e, input logic [9:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] v);
      tick(1);
      sel = 1'b1;
      addr = a;
      wr = w;
      rd = !w;
      wdata = v;
      tick(1);
      sel = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      if (w && a == CP) tick(400);
   endtask
   task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(10'(e));
      bus(a, 1'b0, 8'h00);
   endtask
   function automatic logic [10:0] frame(input logic [7:0] v, input int n, input logic e);
      logic [7:0] m;
      m = v & ~(8'hFF << n);
      frame = {2'b00, m, 1'b0};
      frame[n + 1] = ^m ^ !e;
      frame[n + 2] = 1'b1;
   endfunction
   task automatic tx_char(input logic [7:0] v);
      tx_q.push_back(10'(frame(v, nb, ev) >> 1));
      bus(DP, 1'b1, v);
   endtask
   task automatic wait_tx();
      for (int k = 0; k < 3000 && tx_q.size() != 0; k++) @(posedge clk);
      tick(100);
   endtask
   task automatic rx_char(input logic [10:0] f);
      term_u.send(f, nb + 3);
      tick(20);
   endtask

   always @(posedge clk) begin
      if (rd_seen) chk(exp_q.pop_front(), 10'(rdata));
      rd_seen <= sel && rd;
   end
   always @(posedge got) chk(tx_q.pop_front(), word);

   initial begin
      #800000;
      n_errors++;
      test_done();
   end

   initial begin
      clk = 1'b0;
      bit_clk = 1'b0;
      rst = 1'b1;
      sel = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      dtr = 1'b1;
      rd_seen = 1'b0;
      nb = 8;
      ev = 1'b1;
      seed = $urandom(57633);
      tick(16);
      rst = 1'b0;
      bus(CP, 1'b1, 8'hB7);
      bus(CP, 1'b1, 8'h77);
      for (int l = 0; l < 4; l++) begin
         nb = 5 + l;
         ev = l[0];
         bus(CP, 1'b1, {2'(l % 3 + 1), ev, 1'b1, 2'(l), 2'h2});
         bus(CP, 1'b1, 8'h37);
         d = 8'($urandom);
         tx_char(d);
         wait_tx();
         rd_exp(CP, 8'h05);
         d = 8'($urandom);
         rx_char(frame(d, nb, ev));
         rd_exp(CP, 8'h07);
         rd_exp(DP, d & ~(8'hFF << nb));
         bus(CP, 1'b1, 8'h40);
      end
      chk(10'({dsr, cts}), 10'h000);
      bus(CP, 1'b1, 8'hFE);
      bus(CP, 1'b1, 8'h37);
      chk(10'({dsr, cts}), 10'h003);
      d = 8'($urandom);
      rx_char(frame(d, nb, ev));
      rx_char(frame(d, nb, ev) ^ 11'h200);
      rd_exp(CP, 8'h1F);
      rd_exp(DP, d);
      bus(CP, 1'b1, 8'h27);
      rd_exp(CP, 8'h1D);
      bus(CP, 1'b1, 8'h37);
      rd_exp(CP, 8'h05);
      rx_char(frame(d, nb, ev) & 11'h3FF);
      rd_exp(CP, 8'h27);
      rd_exp(DP, d);
      bus(CP, 1'b1, 8'h37);
      term_u.level(1'b0);
      tick(900);
      rd_exp(CP, 8'h67);
      term_u.level(1'b1);
      tick(20);
      rd_exp(DP, 8'h00);
      bus(CP, 1'b1, 8'h37);
      bus(CP, 1'b1, 8'h33);
      rx_char(frame(d, nb, ev));
      rd_exp(CP, 8'h05);
      bus(CP, 1'b1, 8'h32);
      tx_char(d);
      tick(900);
      rd_exp(CP, 8'h00);
      bus(CP, 1'b1, 8'h37);
      wait_tx();
      rd_exp(CP, 8'h05);
      dtr = 1'b0;
      tick(10);
      tx_char(d);
      tick(900);
      rd_exp(CP, 8'h00);
      dtr = 1'b1;
      wait_tx();
      rd_exp(CP, 8'h05);
      bus(CP, 1'b1, 8'h3F);
      tick(800);
      chk(10'(tx_line), 10'h000);
      bus(CP, 1'b1, 8'h37);
      bus(4'hE, 1'b1, 8'hAA);
      tick(10);
      rd_exp(CP, 8'h05);
      tick(10);
      test_done();
   end
endmodule // asp_port_tb_top
`default_nettype wire

/* File: asp_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_rx (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Setup.
   input wire asp_pkg::asp_mode_t i_mode,
   input wire logic i_bit_tick,
   input wire logic i_enable,
   // Line, already synchronised.
   input wire logic i_line,
   // Character out.
   output asp_pkg::asp_rx_char_t o_char,
   output logic o_done,
   output logic o_break
);
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_state_t;
   asp_rx_state_t state;
   logic [6:0] phase;
   logic [6:0] bit_len;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic parity;
   logic par_err;
   logic all_space;

   always_comb begin
      unique case (i_mode.clock_factor_field)
         asp_pkg::FACTOR_1X: bit_len = 7'h01;
         asp_pkg::FACTOR_16X: bit_len = 7'h10;
         default: bit_len = 7'h40;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= RX_IDLE;
         phase <= 7'h00;
         bit_cnt <= 3'h0;
         shift <= 8'h00;
         parity <= 1'b0;
         par_err <= 1'b0;
         all_space <= 1'b0;
         o_char <= '0;
         o_done <= 1'b0;
         o_break <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (!i_enable) begin
            state <= RX_IDLE;
         end else if (i_bit_tick) begin
            phase <= phase + 7'h01;
            unique case (state)
               RX_IDLE: begin
                  phase <= 7'h00;
                  if (!i_line) begin
                     state <= RX_START;
                  end
               end
               RX_START: begin
                  if (phase == 7'(bit_len >> 1)) begin
                     phase <= 7'h00;
                     state <= i_line ? RX_IDLE : RX_DATA;
                     bit_cnt <= 3'h0;
                     parity <= 1'b0;
                     all_space <= 1'b1;
                     shift <= 8'h00;
                  end
               end
               default: begin
                  if (phase + 7'h01 >= bit_len) begin
                     phase <= 7'h00;
                     if (i_line) begin
                        all_space <= 1'b0;
                     end
                     if (state == RX_DATA) begin
                        shift <= {i_line, shift[7:1]};
                        parity <= parity ^ i_line;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'(3'd4 + 3'(i_mode.char_length_field))) begin
                           state <= i_mode.parity_on ? RX_PAR : RX_STOP;
                        end
                     end else if (state == RX_PAR) begin
                        par_err <= (parity ^ i_line) != ~i_mode.parity_sense;
                        state <= RX_STOP;
                     end else begin
                        // Only one stop bit is checked, whatever the transmit stop length.
                        state <= RX_IDLE;
                        o_done <= 1'b1;
                        o_char.framing_err <= !i_line;
                        o_char.parity_err <= i_mode.parity_on && par_err;
                        o_char.data <= shift >> (3'h3 - i_mode.char_length_field);
                        o_break <= all_space && !i_line;
                        par_err <= 1'b0;
                     end
                  end
               end
            endcase
         end
         if (i_line) begin
            o_break <= 1'b0;
         end
      end
   end
endmodule // asp_rx
`default_nettype wire

/* File: asp_term.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_term #(
   parameter int BIT_NS = 640
) (
   // Serial line from the port.
   input wire logic i_line,
   // Bits after the start bit: data, parity and one stop.
   input wire logic [3:0] i_nbits,
   // Serial line into the port and decoded characters.
   output logic o_line,
   output logic o_got,
   output logic [9:0] o_word
);
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         o_line = f[i];
         #(BIT_NS);
      end
      o_line = 1'b1;
   endtask
   task automatic level(input logic v);
      o_line = v;
   endtask
   // Only the first stop bit is sampled, and a low one is not reported, so a break is never a character.
   initial begin
      o_line = 1'b1;
      o_got = 1'b0;
      o_word = 10'h000;
      forever begin
         @(negedge i_line);
         #(BIT_NS / 2);
         o_word = 10'h000;
         for (int i = 0; i < i_nbits; i++) begin
            #(BIT_NS);
            o_word[i] = i_line;
         end
         if (o_word[i_nbits - 1]) begin
            o_got = 1'b1;
            #5;
            o_got = 1'b0;
         end
      end
   end
endmodule // asp_term
`default_nettype wire

/* File: asp_tx.sv */
`timescale 1ns/1ns
`default_nettype none
module asp_tx (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Setup.
   input wire asp_pkg::asp_mode_t i_mode,
   input wire logic i_bit_tick,
   input wire logic i_break,
   // Character in.
   input wire logic i_start,
   input wire logic [7:0] i_data,
   // Line.
   output logic o_line,
   output logic o_busy
);
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_state_t;
   asp_tx_state_t state;
   logic [7:0] shift;
   logic [2:0] bit_cnt;
   logic [7:0] half_cnt;
   logic [6:0] phase;
   logic [2:0] last_bit;
   logic parity;
   logic [7:0] stop_halves;
   logic [7:0] half_len;

   assign last_bit = 3'(3'd4 + 3'(i_mode.char_length_field));
   always_comb begin
      unique case (i_mode.clock_factor_field)
         asp_pkg::FACTOR_1X: half_len = 8'h01;
         asp_pkg::FACTOR_16X: half_len = 8'h08;
         default: half_len = 8'h20;
      endcase
      if (i_mode.stop_length_field == asp_pkg::STOP_ONE) begin
         stop_halves = 8'h02;
      end else if (i_mode.stop_length_field == asp_pkg::STOP_ONE_HALF) begin
         stop_halves = 8'h03;
      end else begin
         stop_halves = 8'h04;
      end
   end

   // Timing counts in half-bit units so one and a half stop bits fall out exactly; 1x allows only whole halves.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= TX_IDLE;
         shift <= 8'h00;
         bit_cnt <= 3'h0;
         half_cnt <= 8'h00;
         phase <= 7'h00;
         parity <= 1'b0;
         o_line <= 1'b1;
      end else begin
         if (state == TX_IDLE) begin
            phase <= 7'h00;
            half_cnt <= 8'h00;
            if (i_start) begin
               state <= TX_START;
               shift <= i_data;
               parity <= 1'b0;
               bit_cnt <= 3'h0;
            end
         end else if (i_bit_tick) begin
            if (phase + 7'h01 >= 7'(half_len)) begin
               phase <= 7'h00;
               half_cnt <= half_cnt + 8'h01;
            end else begin
               phase <= phase + 7'h01;
            end
            if (phase + 7'h01 >= 7'(half_len) && half_cnt[0]) begin
               unique case (state)
                  TX_START: state <= TX_DATA;
                  TX_DATA: begin
                     parity <= parity ^ shift[0];
                     shift <= {1'b0, shift[7:1]};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == last_bit) begin
                        state <= i_mode.parity_on ? TX_PAR : TX_STOP;
                        half_cnt <= 8'h00;
                     end
                  end
                  TX_PAR: begin
                     state <= TX_STOP;
                     half_cnt <= 8'h00;
                  end
                  default: ;
               endcase
            end
            if (state == TX_STOP && phase + 7'h01 >= 7'(half_len) && half_cnt + 8'h01 >= stop_halves) begin
               state <= TX_IDLE;
            end
         end
         if (i_break) begin
            o_line <= 1'b0;
         end else begin
            unique case (state)
               TX_START: o_line <= 1'b0;
               TX_DATA: o_line <= shift[0];
               TX_PAR: o_line <= parity ^ ~i_mode.parity_sense;
               default: o_line <= 1'b1;
            endcase
         end
      end
   end
   assign o_busy = (state != TX_IDLE);
endmodule // asp_tx
`default_nettype wire
